// [ssp_consts.svh]
/*
 * Register map, field positions and reset values of the serial shift port.
 * Assumes inclusion by bare name from the package and the design files.
 */
`ifndef SSP_CONSTS_SVH
`define SSP_CONSTS_SVH

// ==========================================================
// Register byte addresses
`define SSP_ADDR_DATA   4'h0
`define SSP_ADDR_CTRL   4'h4
`define SSP_ADDR_STAT   4'h8

// ==========================================================
// Control register fields
`define SSP_CTRL_EN     0
`define SSP_CTRL_MASTER 1
`define SSP_CTRL_WORD16 2
`define SSP_CTRL_EIRD   3
`define SSP_CTRL_EIWR   4
`define SSP_CTRL_EDGE   5
`define SSP_CTRL_IDLE   6
`define SSP_CTRL_EIOV   7
`define SSP_CTRL_DIV_LO 8
`define SSP_CTRL_DIV_HI 14
`define SSP_CTRL_RST    16'h0000

// ==========================================================
// Status register fields
`define SSP_ST_BUSY     0
`define SSP_ST_RBF      1
`define SSP_ST_OVR      2

// ==========================================================
// Word lengths in bits
`define SSP_BITS_BYTE   5'h08
`define SSP_BITS_WORD   5'h10

`endif

// [ssp_ctrl.sv]
/*
 * Serial shift port: control, status, shifter and bus slave.
 * Assumes an Avalon-MM master and pins synchronous to clk.
 */
`timescale 1ns/1ps
`include "ssp_consts.svh"
module ssp_ctrl #(
    parameter int DIV_W = 7
) (
    // Clock and reset.
    input  wire logic               clk,
    input  wire logic               reset_n,
    // Avalon-MM slave.
    input  wire ssp_pkg::ssp_addr_t avs_address,
    input  wire logic               avs_read,
    input  wire logic               avs_write,
    input  wire ssp_pkg::ssp_bus_t  avs_writedata,
    output ssp_pkg::ssp_bus_t       avs_readdata,
    output logic                    avs_waitrequest,
    // Shift clock pin.
    input  wire logic               shift_clock_i,
    output logic                    shift_clock_o,
    output logic                    shift_clock_oe,
    // Chip select, slave mode only.
    input  wire logic               port_chip_select_n,
    // Master data out pin.
    input  wire logic               master_out_slave_in_i,
    output logic                    master_out_slave_in_o,
    output logic                    master_out_slave_in_oe,
    // Master data in pin.
    input  wire logic               master_in_slave_out_i,
    output logic                    master_in_slave_out_o,
    output logic                    master_in_slave_out_oe,
    // Interrupt request.
    output logic                    irq
);
    import ssp_pkg::*;

    // ==========================================================
    // Parameter check
    if (DIV_W != 7) begin : g_bad_div
        $error("ssp_ctrl: divider field must be seven bits");
    end

    // Cut a shifter word down to the selected length.
    function automatic ssp_word_t fit_word(input ssp_word_t w,
                                           input logic wide);
        fit_word = wide ? w : {8'h00, w[7:0]};
    endfunction

    // ==========================================================
    // Declarations
    logic             ack_ff;
    logic             acc_req;
    logic             acc_fire;
    logic             wr_data;
    logic             rd_data;
    logic             wr_ctrl;
    logic             wr_stat;
    ssp_bus_t         rdata_ff;
    ssp_word_t        ctrl_ff;
    ssp_word_t        tx_sh_ff;
    ssp_word_t        rx_sh_ff;
    ssp_word_t        buf_ff;
    ssp_word_t        rx_nxt;
    ssp_word_t        rx_final;
    ssp_state_t       state_ff;
    logic [4:0]       bit_cnt_ff;
    logic [5:0]       edge_cnt_ff;
    logic             busy_ff;
    logic             rbf_ff;
    logic             ovr_ff;
    logic             run_ff;
    logic             sck_prev_ff;
    logic             enable;
    logic             master;
    logic             word16;
    logic             en_rd;
    logic             en_wr;
    logic             edge_alt;
    logic             idle_lvl;
    logic             en_ovr;
    logic [DIV_W-1:0] div;
    logic             gen_sck;
    logic             m_rise;
    logic             m_fall;
    logic             cs_act;
    logic             sck_rise;
    logic             sck_fall;
    logic             samp_edge;
    logic             drv_edge;
    logic             lead_edge;
    logic             din;
    logic             cur_bit;
    logic [4:0]       nbits;
    logic             shifting;
    logic             xfer_end;
    logic             m_start;
    logic             s_start;
    logic             buf_free;

    // ==========================================================
    // Bus slave
    // One wait cycle per access; side effects land on the edge where
    // waitrequest is low, so a held request never acts twice.
    assign acc_req         = avs_read | avs_write;
    assign avs_waitrequest = acc_req & ~ack_ff;
    assign acc_fire        = acc_req & ack_ff;
    assign wr_data = acc_fire & avs_write & (avs_address == `SSP_ADDR_DATA);
    assign rd_data = acc_fire & avs_read & (avs_address == `SSP_ADDR_DATA);
    assign wr_ctrl = acc_fire & avs_write & (avs_address == `SSP_ADDR_CTRL);
    assign wr_stat = acc_fire & avs_write & (avs_address == `SSP_ADDR_STAT);

    // Acknowledge is high for one cycle per access.
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            ack_ff <= 1'b0;
        end else begin
            ack_ff <= acc_req & ~ack_ff;
        end
    end

    // Read data is latched in the wait cycle; unmapped reads give zero.
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            rdata_ff <= '0;
        end else if (avs_read && !ack_ff) begin
            unique case (avs_address)
                `SSP_ADDR_DATA: rdata_ff <= {16'h0000, buf_ff};
                `SSP_ADDR_CTRL: rdata_ff <= {16'h0000, ctrl_ff};
                `SSP_ADDR_STAT: rdata_ff <= {29'h0, ovr_ff, rbf_ff, busy_ff};
                default:        rdata_ff <= '0;
            endcase
        end
    end
    assign avs_readdata = rdata_ff;

    // ==========================================================
    // Control register
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            ctrl_ff <= `SSP_CTRL_RST;
        end else if (wr_ctrl) begin
            ctrl_ff <= avs_writedata[15:0];
        end
    end

    assign enable   = ctrl_ff[`SSP_CTRL_EN];
    assign master   = ctrl_ff[`SSP_CTRL_MASTER];
    assign word16   = ctrl_ff[`SSP_CTRL_WORD16];
    assign en_rd    = ctrl_ff[`SSP_CTRL_EIRD];
    assign en_wr    = ctrl_ff[`SSP_CTRL_EIWR];
    assign edge_alt = ctrl_ff[`SSP_CTRL_EDGE];
    assign idle_lvl = ctrl_ff[`SSP_CTRL_IDLE];
    assign en_ovr   = ctrl_ff[`SSP_CTRL_EIOV];
    assign div      = ctrl_ff[`SSP_CTRL_DIV_HI:`SSP_CTRL_DIV_LO];
    assign nbits    = word16 ? `SSP_BITS_WORD : `SSP_BITS_BYTE;

    // ==========================================================
    // Shift clock and edges
    // The divider only feeds the master generator; a slave takes
    // its edges from the pin and never looks at it.
    ssp_sck_gen #(
        .DIV_W      (DIV_W)
    ) u_sck_gen (
        .clk        (clk),
        .reset_n    (reset_n),
        .run        (run_ff),
        .divider    (div),
        .idle_level (idle_lvl),
        .sck_o      (gen_sck),
        .rise_p     (m_rise),
        .fall_p     (m_fall)
    );

    // Previous pin level for slave edge detection.
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            sck_prev_ff <= shift_clock_i;  // No false edge when the pin idles high.
        end else begin
            sck_prev_ff <= shift_clock_i;
        end
    end

    assign cs_act   = enable & ~master & ~port_chip_select_n;
    assign sck_rise = master ? m_rise : (cs_act & shift_clock_i & ~sck_prev_ff);
    assign sck_fall = master ? m_fall : (cs_act & ~shift_clock_i & sck_prev_ff);
    // Edge roles swap with the edge mode bit.
    assign samp_edge = edge_alt ? sck_fall : sck_rise;
    assign drv_edge  = edge_alt ? sck_rise : sck_fall;
    assign lead_edge = idle_lvl ? sck_fall : sck_rise;

    // ==========================================================
    // Transfer control
    assign shifting = (state_ff == st_shift);
    assign din      = master ? master_in_slave_out_i : master_out_slave_in_i;
    assign rx_nxt   = {rx_sh_ff[14:0], din};
    // A master waits for the clock to return idle; a slave ends on
    // its last sample since the trailing edge may never come.
    assign xfer_end = shifting & (master
                    ? ((m_rise | m_fall) && edge_cnt_ff == {nbits, 1'b0} - 6'd1)
                    : (samp_edge && bit_cnt_ff == nbits - 5'd1));
    assign rx_final = fit_word(master ? rx_sh_ff : rx_nxt, word16);
    assign m_start  = wr_data & enable & master & ~run_ff & ~shifting;
    assign s_start  = lead_edge & cs_act & (state_ff == st_idle);
    assign buf_free = ~rbf_ff | rd_data;

    // Shifter state: idle, shifting, or holding data for the buffer.
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            state_ff <= st_idle;
        end else if (m_start || s_start) begin
            state_ff <= st_shift;
        end else if (!master && port_chip_select_n && shifting) begin
            state_ff <= st_idle;
        end else if (xfer_end) begin
            state_ff <= buf_free ? st_idle : st_hold;
        end else if (rd_data && state_ff == st_hold) begin
            state_ff <= st_idle;
        end
    end

    // Master clock runs for twice the word length in edges.
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            run_ff <= 1'b0;
        end else if (m_start) begin
            run_ff <= 1'b1;
        end else if (xfer_end || !enable || !master) begin
            run_ff <= 1'b0;
        end
    end

    // Edge and sample counters; a deselected slave restarts its count.
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            edge_cnt_ff <= '0;
            bit_cnt_ff  <= '0;
        end else if (m_start || !shifting) begin
            edge_cnt_ff <= '0;
            bit_cnt_ff  <= '0;
        end else begin
            if (m_rise || m_fall) begin
                edge_cnt_ff <= edge_cnt_ff + 6'd1;
            end
            if (samp_edge) begin
                bit_cnt_ff <= bit_cnt_ff + 5'd1;
            end
        end
    end

    // ==========================================================
    // Shift registers
    // The first drive edge only repeats the top bit when it comes
    // before any sample, so shifting waits for one sample.
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            tx_sh_ff <= '0;
        end else if (wr_data && !shifting) begin
            tx_sh_ff <= avs_writedata[15:0];
        end else if (shifting && drv_edge && bit_cnt_ff != 5'd0) begin
            tx_sh_ff <= {tx_sh_ff[14:0], 1'b0};
        end
    end

    // Input bits enter at the bottom on every sample edge while shifting.
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            rx_sh_ff <= '0;
        end else if (shifting && samp_edge) begin
            rx_sh_ff <= rx_nxt;
        end
    end

    // Read buffer loads at the end of a transfer or on reload.
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            buf_ff <= '0;
        end else if (xfer_end && buf_free) begin
            buf_ff <= rx_final;
        end else if (rd_data && state_ff == st_hold) begin
            buf_ff <= fit_word(rx_sh_ff, word16);
        end
    end

    // ==========================================================
    // Status flags
    // Busy sets on start or on a slave data write and clears only once the buffer took the data.
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            busy_ff <= 1'b0;
        end else if (m_start) begin
            busy_ff <= 1'b1;
        end else if (!master && (s_start || (wr_data && enable))) begin
            busy_ff <= 1'b1;
        end else if (xfer_end && buf_free) begin
            busy_ff <= 1'b0;
        end else if (rd_data && state_ff == st_hold) begin
            busy_ff <= 1'b0;
        end
    end

    // Buffer-full: a load wins over a read in the same cycle.
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            rbf_ff <= 1'b0;
        end else if (xfer_end && buf_free) begin
            rbf_ff <= 1'b1;
        end else if (rd_data && state_ff != st_hold) begin
            rbf_ff <= 1'b0;
        end
    end

    // Overrun is sticky; a new overrun beats a write-one clear.
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            ovr_ff <= 1'b0;
        end else if (m_start && rbf_ff && state_ff == st_hold) begin
            ovr_ff <= 1'b1;
        end else if (wr_stat && avs_writedata[`SSP_ST_OVR]) begin
            ovr_ff <= 1'b0;
        end
    end

    // ==========================================================
    // Pins and interrupt
    // Data and clock leave the chip only in the mode that owns them.
    assign cur_bit                = word16 ? tx_sh_ff[15] : tx_sh_ff[7];
    assign shift_clock_o          = gen_sck;
    assign shift_clock_oe         = enable & master;
    assign master_out_slave_in_o  = cur_bit;
    assign master_out_slave_in_oe = enable & master;
    assign master_in_slave_out_o  = cur_bit;
    assign master_in_slave_out_oe = cs_act;

    // Level request, held while any enabled condition stays true; the overrun term counts in master mode only.
    assign irq = (en_rd & rbf_ff)
               | (en_wr & ~busy_ff)
               | (en_ovr & ovr_ff & master);

    // ==========================================================
    // Assertions
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    sequence s_mstart;
        m_start;
    endsequence

    sequence s_running;
        run_ff [*2];
    endsequence

    irq_read_full_a: assert property (en_rd && rbf_ff |-> irq)
        else $error("read-full interrupt missing");

    irq_xfer_done_a: assert property ($fell(busy_ff) && en_wr |-> irq)
        else $error("transfer-done interrupt missing");

    normal_no_shift_a: assert property (
        shifting && !edge_alt && sck_rise && !wr_data |=> $stable(tx_sh_ff))
        else $error("output shifted on rising edge in normal mode");

    alt_no_shift_a: assert property (
        shifting && edge_alt && sck_fall && !wr_data |=> $stable(tx_sh_ff))
        else $error("output shifted on falling edge in alternate mode");

    clock_idle_a: assert property (
        !run_ff && $past(!run_ff) && $stable(idle_lvl) |-> gen_sck == idle_lvl)
        else $error("shift clock not at idle level");

    master_busy_a: assert property (m_start |=> busy_ff)
        else $error("busy not set after master write");

    master_run_a: assert property (s_mstart |=> s_running)
        else $error("master clock did not start");

    hold_busy_a: assert property (state_ff == st_hold |-> busy_ff)
        else $error("busy dropped while shifter holds data");

    read_clear_a: assert property (
        rd_data && state_ff != st_hold && !xfer_end |=> !rbf_ff)
        else $error("buffer-full not cleared on read");

    overrun_sticky_a: assert property (
        ovr_ff && !(wr_stat && avs_writedata[`SSP_ST_OVR]) |=> ovr_ff)
        else $error("overrun flag lost without clear");

    slave_tristate_a: assert property (port_chip_select_n |-> !master_in_slave_out_oe)
        else $error("slave output driven while deselected");
endmodule

// [ssp_pkg.sv]
/*
 * Types shared by the serial shift port design files.
 * Assumes the constants header is on the include path.
 */
package ssp_pkg;
    `include "ssp_consts.svh"

    // Bus word, register word and shifter state.
    typedef logic [31:0] ssp_bus_t;
    typedef logic [15:0] ssp_word_t;
    typedef logic [3:0]  ssp_addr_t;
    typedef enum logic [1:0] {st_idle, st_shift, st_hold} ssp_state_t;
endpackage

// [ssp_remote_slave.sv]
/*
 * Remote serial slave for the shift port bench: normal edge mode, clock idle low.
 * Assumes the bench pulses load before each frame and the master makes the clock.
 */
`timescale 1ns/1ps
module ssp_remote_slave (
    // Link pins.
    input  wire logic       sck,
    input  wire logic       mosi,
    output logic            miso,
    // Bench side.
    input  wire logic       load,
    input  wire logic [7:0] tx_byte,
    output logic [7:0]      rx_byte
);
    logic [7:0] sh;

    // ==========================================================
    // Shifter: sample on the rise, advance on the fall, so data never moves on a sample.
    always @(posedge sck) rx_byte = {rx_byte[6:0], mosi};
    // Freed bits refill with a toggling pattern, so stale data cannot look valid.
    // One process owns the shifter, so a load and a shift never fight over it.
    always @(posedge load or negedge sck) begin
        if (load) begin
            sh = tx_byte;
        end else begin
            sh = {sh[6:0], ~sh[0]};
        end
    end
    assign miso = sh[7];
endmodule

// [ssp_sck_gen.sv]
/*
 * Master shift clock generator: half period of divider plus one clocks.
 * Assumes run is dropped by the caller in the cycle after the last edge.
 */
`timescale 1ns/1ps
module ssp_sck_gen #(
    parameter int DIV_W = 7
) (
    // Clock and reset.
    input  wire logic             clk,
    input  wire logic             reset_n,
    // Control.
    input  wire logic             run,
    input  wire logic [DIV_W-1:0] divider,
    input  wire logic             idle_level,
    // Clock out and edge pulses.
    output logic                  sck_o,
    output logic                  rise_p,
    output logic                  fall_p
);
    logic [DIV_W-1:0] cnt_ff;
    logic             sck_ff;
    logic             tick;

    // ==========================================================
    // Half period counter
    // A tick every divider plus one cycles gives a divisor of twice that.
    assign tick = run & (cnt_ff == divider);

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            cnt_ff <= '0;
        end else if (!run || tick) begin
            cnt_ff <= '0;
        end else begin
            cnt_ff <= cnt_ff + 1'b1;
        end
    end

    // Clock sits at the idle level whenever no transfer runs.
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            sck_ff <= 1'b0;
        end else if (!run) begin
            sck_ff <= idle_level;
        end else if (tick) begin
            sck_ff <= ~sck_ff;
        end
    end

    // Edge pulses mark the cycle in which the clock changes.
    assign sck_o  = sck_ff;
    assign rise_p = tick & ~sck_ff;
    assign fall_p = tick & sck_ff;
endmodule

// [sync_serial_shift_port_ctrl_bench.sv]
/*
 * Self-checking bench of the serial shift port in master mode and slave select.
 * Assumes the design files and the constants header are compiled before it.
 */
`timescale 1ns/1ps
`include "ssp_consts.svh"
module sync_serial_shift_port_ctrl_bench;
    import ssp_pkg::*;
    logic       clk       = 1'b0;
    logic       reset_n   = 1'b0;
    ssp_addr_t  avs_address   = '0;
    logic       avs_read  = 1'b0;
    logic       avs_write = 1'b0;
    ssp_bus_t   avs_writedata = '0;
    ssp_bus_t   avs_readdata;
    logic       avs_waitrequest;
    logic       sck;
    logic       mosi;
    logic       miso;
    logic       miso_oe;
    logic       sck_oe;
    logic       mosi_oe;
    logic       so;
    logic       irq;
    logic       cs_n      = 1'b1;
    logic       load      = 1'b0;
    logic [7:0] rx_byte;
    int         err_count = 0;
    int         samples_checked = 0;
    int         rise_cnt  = 0;
    int         high_cnt  = 0;
    ssp_bus_t   q;

    // ==========================================================
    // Clock and link edge counters.
    always #10 clk = ~clk;
    always @(posedge sck) rise_cnt++;
    always @(posedge clk) if (sck === 1'b1) high_cnt++;

    ssp_ctrl i_ssp_ctrl (
        .clk(clk), .reset_n(reset_n), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .shift_clock_i(1'b0), .shift_clock_o(sck),
        .shift_clock_oe(sck_oe), .port_chip_select_n(cs_n), .master_out_slave_in_i(1'b0),
        .master_out_slave_in_o(mosi), .master_out_slave_in_oe(mosi_oe),
        .master_in_slave_out_i(miso), .master_in_slave_out_o(so),
        .master_in_slave_out_oe(miso_oe), .irq(irq));

    ssp_remote_slave i_ssp_remote_slave (
        .sck(sck), .mosi(mosi), .miso(miso), .load(load), .tx_byte(8'h3c),
        .rx_byte(rx_byte));

    // ==========================================================
    // Shared tasks.
    task automatic complete_run();
        if (err_count == 0 && samples_checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask

    // One bus cycle; held until waitrequest is seen low at a rising edge.
    task automatic bus(input logic wr, input ssp_addr_t a, input ssp_word_t d);
        int n;
        n = 0;
        avs_address   <= a;
        avs_writedata <= {16'h0000, d};
        avs_write     <= wr;
        avs_read      <= ~wr;
        do begin
            @(posedge clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 100);
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read  <= 1'b0;
        @(posedge clk);
        if (n >= 100) begin
            err_count++;
            complete_run();
        end
    endtask

    // Frame start: the slave reloads its byte, then the data write starts the master.
    task automatic xfer(input logic [7:0] d);
        load <= 1'b1;
        @(posedge clk);
        load <= 1'b0;
        bus(1'b1, `SSP_ADDR_DATA, {8'h00, d});
    endtask

    // Polls status until busy drops; a hang ends the run.
    task automatic wait_idle();
        int n;
        n = 0;
        do begin
            bus(1'b0, `SSP_ADDR_STAT, 16'h0000);
            n++;
        end while (q[0] !== 1'b0 && n < 200);
        if (n >= 200) begin
            err_count++;
            complete_run();
        end
    endtask

    // ==========================================================
    // Scenarios.
    task automatic t_reset();
        bus(1'b0, `SSP_ADDR_CTRL, 16'h0000);
        check("control", 32'h0, q);
        bus(1'b0, `SSP_ADDR_STAT, 16'h0000);
        check("status", 32'h0, q);
        bus(1'b0, 4'hc, 16'h0000);
        check("unmapped", 32'h0, q);
        check("irq", 32'h0, irq);
        check("sck idle", 32'h0, sck);
    endtask

    // Enable, master, read-full interrupt, divider 1: half period of two cycles.
    task automatic t_master();
        bus(1'b1, `SSP_ADDR_CTRL, 16'h010b);
        rise_cnt = 0;
        high_cnt = 0;
        xfer(8'ha5);
        bus(1'b0, `SSP_ADDR_STAT, 16'h0000);
        check("busy", 32'h1, q[0]);
        wait_idle();
        check("status", 32'h2, q);
        check("irq", 32'h1, irq);
        check("edges", 32'd8, rise_cnt);
        check("high", 32'd16, high_cnt);
        check("sent", 32'ha5, rx_byte);
        bus(1'b0, `SSP_ADDR_DATA, 16'h0000);
        check("data", 32'h3c, q);
        bus(1'b0, `SSP_ADDR_STAT, 16'h0000);
        check("status", 32'h0, q);
        check("irq", 32'h0, irq);
        bus(1'b1, `SSP_ADDR_CTRL, 16'h0113);
        check("irq", 32'h1, irq);
    endtask

    // Overrun interrupt only; buffer and shifter both filled before the third start.
    task automatic t_overrun();
        bus(1'b1, `SSP_ADDR_CTRL, 16'h0183);
        xfer(8'h11);
        wait_idle();
        xfer(8'h33);
        repeat (60) @(posedge clk);
        bus(1'b0, `SSP_ADDR_STAT, 16'h0000);
        check("status", 32'h3, q);
        check("irq", 32'h0, irq);
        xfer(8'h55);
        bus(1'b0, `SSP_ADDR_STAT, 16'h0000);
        check("overrun", 32'h1, q[2]);
        check("irq", 32'h1, irq);
        bus(1'b1, `SSP_ADDR_STAT, 16'h0000);
        bus(1'b0, `SSP_ADDR_STAT, 16'h0000);
        check("overrun", 32'h1, q[2]);
        bus(1'b1, `SSP_ADDR_STAT, 16'h0004);
        bus(1'b0, `SSP_ADDR_STAT, 16'h0000);
        check("cleared", 32'h1, q[2:1]);
        // Let the third frame finish into the shifter so the read must reload.
        repeat (60) @(posedge clk);
        bus(1'b0, `SSP_ADDR_DATA, 16'h0000);
        check("data", 32'h3c, q);
        bus(1'b0, `SSP_ADDR_STAT, 16'h0000);
        check("reload", 32'h1, q[1]);
        for (int i = 0; i < 4 && q !== 32'h0; i++) begin
            repeat (60) @(posedge clk);
            bus(1'b0, `SSP_ADDR_DATA, 16'h0000);
            bus(1'b0, `SSP_ADDR_STAT, 16'h0000);
        end
        check("drained", 32'h0, q);
    endtask

    // Idle level changed only with busy clear; then slave output follows select.
    task automatic t_idle_slave();
        bus(1'b1, `SSP_ADDR_CTRL, 16'h0143);
        // The clock register takes the new idle level one edge after the write.
        @(posedge clk);
        check("sck idle", 32'h1, sck);
        check("sck oe", 32'h1, sck_oe);
        check("mosi oe", 32'h1, mosi_oe);
        bus(1'b1, `SSP_ADDR_CTRL, 16'h0001);
        check("oe off", 32'h0, miso_oe);
        check("sck oe", 32'h0, sck_oe);
        bus(1'b1, `SSP_ADDR_DATA, 16'h0080);
        bus(1'b0, `SSP_ADDR_STAT, 16'h0000);
        check("slave busy", 32'h1, q[0]);
        cs_n <= 1'b0;
        repeat (2) @(posedge clk);
        check("oe on", 32'h1, miso_oe);
        check("slave out", 32'h1, so);
        cs_n <= 1'b1;
        repeat (2) @(posedge clk);
        check("oe off", 32'h0, miso_oe);
    endtask

    // ==========================================================
    // Main sequence.
    initial begin
        repeat (12) @(posedge clk);
        reset_n <= 1'b1;
        t_reset();
        t_master();
        t_overrun();
        t_idle_slave();
        complete_run();
    end
endmodule
